// *** shared/ced_defines.svh ***
// Constants for the configuration error detect block.
// Included by the package and the error detect module; definitions only.
`ifndef CED_DEFINES_SVH
`define CED_DEFINES_SVH

// 40 MHz ref clock; serial clock = ref / (2 * half period)
`define CED_CLK_PERIOD_NS      25
`define CED_SCLK_HALF_CYC      8'h04
`define CED_POST_WAIT_CLKS     8'h10
`define CED_ADDR_W             21
`define CED_ADDR_ZERO          21'h000000
`define CED_BIT_COUNT_DEF      21'h000400
`define CED_POR_CYC_DEF        24'h000100
`define CED_SUPPLY_5V0         1'h0
`define CED_SUPPLY_3V3         1'h1

`endif

// *** shared/ced_pkg.sv ***
// Types shared by the configuration error detect design.
// Assumes ced_defines.svh is reachable on the include path.
`include "ced_defines.svh"

package ced_pkg;

    typedef enum logic [2:0] {
        CED_POR,
        CED_IDLE,
        CED_SEND,
        CED_WAIT_DONE,
        CED_ERROR,
        CED_FINISHED
    } ced_state_e;

    typedef logic [`CED_ADDR_W-1:0] ced_addr_t;

endpackage : ced_pkg

// *** rtl/ced_sync2.sv ***
// Two-flop synchroniser for one pin input.
// Assumes the input is asynchronous to ref_clk; first flop feeds only the second.
`timescale 1ns/1ps

module ced_sync2 (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic rst_val,
    input  wire logic pin_in,
    output logic      sync_out
);

    logic meta;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            meta     <= rst_val;
            sync_out <= rst_val;
        end else begin
            meta     <= pin_in;
            sync_out <= meta;
        end
    end

endmodule : ced_sync2

// *** rtl/ced_config_error_detect.sv ***
// Serial configuration master with error detection and restart.
// Assumes a 40 MHz ref_clk; pins come from another party and are synchronised here.
//
// Function
// - Early done rise aborts and pulls enable low
// - Wait 16 serial clocks for done after data
// - Missing done after wait pulls enable low
// - Auto-restart option restarts after an error
// - External low on enable resets the device
// - Supply select low 5 V, high 3.3 V
// - Start instruction begins target configuration
// - Enable low clears counter, floats data
// - Hold enable low during power-on reset
// - After done, idle with serial clock low
`timescale 1ns/1ps
`include "ced_defines.svh"

module ced_config_error_detect
    import ced_pkg::*;
#(
    parameter logic [`CED_ADDR_W-1:0] BIT_COUNT = `CED_BIT_COUNT_DEF,
    parameter logic [23:0]            POR_CYC   = `CED_POR_CYC_DEF
) (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic       chip_select_low_in,
    input  wire logic       oe_in,
    output logic            oe_out,
    output logic            oe_oe,
    output logic            serial_clock_out,
    output logic            data_out,
    output logic            data_oe,
    output logic            mem_rd,
    output logic [`CED_ADDR_W-1:0] mem_addr,
    input  wire logic       mem_bit,
    input  wire logic       auto_restart,
    input  wire logic       supply_level_select,
    output logic            low_voltage_mode,
    input  wire logic       start_config_instruction,
    output logic            config_error,
    output logic            config_done
);

    ced_state_e state;
    ced_state_e next_state;
    logic       cs_low_s;
    logic       oe_s;
    logic       ext_oe_low;
    logic [7:0] div_cnt;
    logic       sel_s;
    logic       sclk_fall;
    logic [7:0] wait_cnt;
    logic [23:0] por_cnt;
    ced_addr_t  addr;
    logic       last_bit;

    ced_sync2 u_sync_cs (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .rst_val  (1'b1),
        .pin_in   (chip_select_low_in),
        .sync_out (cs_low_s)
    );

    ced_sync2 u_sync_oe (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .rst_val  (1'b1),
        .pin_in   (oe_in),
        .sync_out (oe_s)
    );

    // Strap pin is static, but it still enters from outside the clock domain
    ced_sync2 u_sync_sel (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .rst_val  (`CED_SUPPLY_5V0),
        .pin_in   (supply_level_select),
        .sync_out (sel_s)
    );

    // Line low while we are not pulling it means someone else pulled it
    assign ext_oe_low = !oe_s && !oe_oe;

    function automatic logic drives_low(input ced_state_e s);
        drives_low = (s == CED_POR) || (s == CED_ERROR);
    endfunction : drives_low

    function automatic logic runs_clock(input ced_state_e s);
        runs_clock = (s == CED_SEND) || (s == CED_WAIT_DONE);
    endfunction : runs_clock

    // Divider stops on the leaving edge, so idle never starts with the clock high
    always_ff @(posedge ref_clk) begin
        if (!resetn || !runs_clock(state) || !runs_clock(next_state)) begin
            div_cnt          <= 8'h00;
            serial_clock_out <= 1'b0;
        end else if (div_cnt == `CED_SCLK_HALF_CYC - 8'h01) begin
            div_cnt          <= 8'h00;
            serial_clock_out <= !serial_clock_out;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    assign sclk_fall = (div_cnt == `CED_SCLK_HALF_CYC - 8'h01) && serial_clock_out;
    assign last_bit  = (addr == BIT_COUNT - `CED_ADDR_W'(1));

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            por_cnt <= 24'h000000;
        end else if (state == CED_POR) begin
            por_cnt <= por_cnt + 24'h000001;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            CED_POR: begin
                if (por_cnt >= POR_CYC - 24'h000001) begin
                    next_state = CED_IDLE;
                end
            end
            CED_IDLE: begin
                // Master only starts with done low
                if (!cs_low_s && oe_s) begin
                    next_state = CED_SEND;
                end
            end
            CED_SEND: begin
                if (cs_low_s) begin
                    next_state = CED_ERROR;
                end else if (sclk_fall && last_bit) begin
                    next_state = CED_WAIT_DONE;
                end
            end
            CED_WAIT_DONE: begin
                if (cs_low_s) begin
                    next_state = CED_FINISHED;
                end else if (sclk_fall && wait_cnt == `CED_POST_WAIT_CLKS - 8'h01) begin
                    next_state = CED_ERROR;
                end
            end
            CED_ERROR: begin
                if (auto_restart) begin
                    next_state = CED_IDLE;
                end
            end
            CED_FINISHED: begin
                next_state = CED_FINISHED;
            end
            default: next_state = CED_IDLE;
        endcase
        if (state != CED_POR && start_config_instruction) begin
            next_state = CED_IDLE;
        end
        if (ext_oe_low) begin
            next_state = CED_IDLE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            state <= CED_POR;
        end else begin
            state <= next_state;
        end
    end

    // Error state holds until a restart, start instruction or reset
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            config_error <= 1'b0;
        end else if (next_state == CED_ERROR) begin
            config_error <= 1'b1;
        end else if (next_state == CED_SEND) begin
            config_error <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            config_done <= 1'b0;
        end else begin
            config_done <= (next_state == CED_FINISHED);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn || !oe_s || state != CED_WAIT_DONE) begin
            wait_cnt <= 8'h00;
        end else if (sclk_fall) begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end

    // Address counter cleared whenever enable line reads low
    always_ff @(posedge ref_clk) begin
        if (!resetn || !oe_s || state != CED_SEND) begin
            addr <= `CED_ADDR_ZERO;
        end else if (sclk_fall && !last_bit) begin
            addr <= addr + `CED_ADDR_W'(1);
        end
    end

    assign mem_addr = addr;
    assign mem_rd   = (state == CED_SEND);

    // Data changes after the falling edge, target samples on rising edge
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            data_out <= 1'b0;
            data_oe  <= 1'b0;
        end else if (!oe_s || state != CED_SEND) begin
            data_out <= 1'b0;
            data_oe  <= 1'b0;
        end else begin
            data_out <= mem_bit;
            data_oe  <= 1'b1;
        end
    end

    // Open drain: only ever drives low
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            oe_oe <= 1'b1;
        end else begin
            oe_oe <= drives_low(next_state);
        end
    end

    assign oe_out = 1'b0;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            low_voltage_mode <= `CED_SUPPLY_5V0;
        end else begin
            low_voltage_mode <= (sel_s == `CED_SUPPLY_3V3);
        end
    end

endmodule : ced_config_error_detect

// *** tb/ced_target_model.sv ***
// Target model: counts serial clock rises, captures data, answers done or status.
// Assumes the bench forms the shared enable line with a pull-up.
`timescale 1ns/1ps
module ced_target_model (
    input  wire logic       ref_clk,
    input  wire logic       arm,
    input  wire logic [1:0] mode,
    input  wire logic       sclk,
    input  wire logic       data_out,
    input  wire logic       data_oe,
    output logic            done,
    output logic            status_pull,
    output logic [7:0]      rx
);
    logic       sclk_d;
    logic [4:0] cnt;
    always_ff @(posedge ref_clk) begin
        sclk_d <= sclk;
        if (!arm) cnt <= 5'h00;
        else if (sclk && !sclk_d && cnt != 5'h1F) cnt <= cnt + 5'h01;
        if (sclk && !sclk_d && data_oe && cnt < 5'h08) rx[cnt[2:0]] <= data_out;
    end
    // Done two clocks after the last bit; mode 1 early, mode 2 never
    assign done = mode == 2'h0 ? cnt >= 5'h0A : mode == 2'h1 && cnt >= 5'h03;
    assign status_pull = mode == 2'h3 && cnt == 5'h04;
endmodule : ced_target_model

// *** tb/ced_props.sv ***
// Port checker for the error detect block.
// Assumes a bind to its top module; one clock.
`timescale 1ns/1ps
module ced_props (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic chip_select_low_in,
    input wire logic oe_in,
    input wire logic oe_oe,
    input wire logic serial_clock_out,
    input wire logic data_oe,
    input wire logic mem_rd,
    input wire logic auto_restart,
    input wire logic config_error,
    input wire logic config_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    chk_por_hold: assert property ($rose(resetn) |-> oe_oe [*3]) else $error("por");
    chk_early_abort: assert property (chip_select_low_in && mem_rd |-> ##[1:6] config_error)
        else $error("early");
    chk_error_pull: assert property ($rose(config_error) |-> ##[0:1] oe_oe)
        else $error("pull");
    chk_ext_float: assert property (!oe_in && !oe_oe |-> ##[1:5] !data_oe && !mem_rd)
        else $error("float");
    chk_wait_bound: assert property ($fell(mem_rd) && oe_in |->
        ##[1:150] (config_done || config_error)) else $error("wait");
    chk_idle_sclk: assert property (config_done |-> !serial_clock_out) else $error("sclk");
    chk_hold_err: assert property ($rose(config_error) && !auto_restart |=>
        (oe_oe && !data_oe) [*8]) else $error("hold");
    chk_done_cause: assert property ($rose(config_done) |-> $past(chip_select_low_in, 2))
        else $error("done");
    cover property (config_done);
    cover property ($rose(config_error) && auto_restart);
    cover property (!oe_in && !oe_oe);
endmodule : ced_props

// *** tb/testbench.sv ***
// Bench top: error paths of the block against the target model.
// Assumes package, design, model and checker compile first.
`timescale 1ns/1ps
module testbench;
    import ced_pkg::*;
    logic ref_clk = 0, resetn = 0, auto_restart = 0, supply_level_select = 0, arm = 0;
    logic start_config_instruction = 0, pull, chip_select_low_in, oe_oe, serial_clock_out;
    logic data_out, data_oe, mem_rd, low_voltage_mode, config_error, config_done, oe_out;
    logic [1:0] mode = 0;
    logic [7:0] rx;
    ced_addr_t mem_addr;
    int bad_count = 0, n_checks = 0;
    time t0;
    // Open-drain line with pull-up; either side may pull it low
    wire oe_in = (oe_oe ? oe_out : 1'b1) && !pull;
    wire mem_bit = mem_addr < 3;
    wire [3:0] st = {data_oe, mem_rd, config_error, config_done};
    ced_config_error_detect #(.BIT_COUNT(21'h000008), .POR_CYC(24'h000004)) i_dut (.ref_clk,
        .resetn, .chip_select_low_in, .oe_in, .oe_out, .oe_oe, .serial_clock_out, .data_out,
        .data_oe, .mem_rd, .mem_addr, .mem_bit, .auto_restart, .supply_level_select,
        .low_voltage_mode, .start_config_instruction, .config_error, .config_done);
    ced_target_model i_tgt (.ref_clk, .arm, .mode, .sclk(serial_clock_out), .data_out,
        .data_oe, .done(chip_select_low_in), .status_pull(pull), .rx);
    initial forever #12.5 ref_clk = ~ref_clk;
    task chk(input logic [7:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %h %h", $time, got, exp);
        end
    endtask : chk
    task stop_test;
        $display("checks %0d bad %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : stop_test
    task wt(input int s, input logic v);
        for (int i = 0; i < 400; i++) begin
            @(posedge ref_clk) #1;
            if (st[s] === v) return;
        end
        bad_count++;
        stop_test();
    endtask : wt
    // Re-arming the model drops done; mode moves with the re-arm so done cannot glitch
    task go(input logic [1:0] m, input logic s);
        @(posedge ref_clk) arm <= 0;
        start_config_instruction <= s;
        @(posedge ref_clk) arm <= 1;
        mode <= m;
        start_config_instruction <= 0;
    endtask : go
    task t_good;
        wt(0, 1);
        chk(rx, 8'h07);
        chk({7'h0, serial_clock_out}, 8'h00);
        chk({7'h0, low_voltage_mode}, 8'h00);
        @(posedge ref_clk) supply_level_select <= 1;
        repeat (4) @(posedge ref_clk);
        #1;
        chk({7'h0, low_voltage_mode}, 8'h01);
        $display("good end");
    endtask : t_good
    task t_early;
        go(1, 1);
        wt(1, 1);
        chk({7'h0, oe_oe}, 8'h01);
        repeat (40) @(posedge ref_clk);
        #1;
        chk({6'h0, data_oe, oe_oe}, 8'h01);
        $display("early end");
    endtask : t_early
    task t_auto;
        @(posedge ref_clk) auto_restart <= 1;
        go(2, 1);
        wt(2, 1);
        wt(2, 0);
        t0 = $time;
        wt(1, 1);
        chk(8'(($time - t0) / 25), 8'h80);
        chk({7'h0, oe_oe}, 8'h01);
        go(0, 0);
        wt(2, 1);
        wt(0, 1);
        $display("auto end");
    endtask : t_auto
    task t_crc;
        go(3, 1);
        wt(3, 1);
        wt(3, 0);
        repeat (2) @(posedge ref_clk);
        #1;
        chk({7'h0, mem_addr != 0}, 8'h00);
        go(0, 0);
        wt(0, 1);
        $display("crc end");
    endtask : t_crc
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1;
        arm <= 1;
        t_good();
        t_early();
        t_auto();
        t_crc();
        stop_test();
    end
endmodule : testbench
bind ced_config_error_detect ced_props i_chk (
    .ref_clk            (ref_clk),
    .resetn             (resetn),
    .chip_select_low_in (chip_select_low_in),
    .oe_in              (oe_in),
    .oe_oe              (oe_oe),
    .serial_clock_out   (serial_clock_out),
    .data_oe            (data_oe),
    .mem_rd             (mem_rd),
    .auto_restart       (auto_restart),
    .config_error       (config_error),
    .config_done        (config_done)
);
